// [sfw_core.sv]
// Notes on behaviour
// - first byte is the opcode; 06h sets the write latch, 04h resets it
// - 03h is memory read, 0Bh fast read, 02h memory write
// - B9h enters sleep, 9Fh reads identity; nine valid commands in all
// - unknown opcode: do nothing, ignore input until next select, output stays off
// - one opcode per select period; master deselects between operations
// - after reset the write latch is clear and its flag reads 0
// - latch-set must precede status or memory writes; writes refused while clear
// - latch flag is set only by latch-set; status write cannot set it
// - latch clears on deselect ending latch-reset, status write or memory write
// - latch-reset disables writes; a later status read shows flag 0
// - status bit 7 protect enable, bits 3..2 block protect, bit 1 latch
// - status bits 0 and 4..6 are not writable and read zero
// - block-protect bits survive power cycles in nonvolatile storage
// - protect 00 none, 01 6000h-7FFFh, 10 4000h-7FFFh, 11 whole array
// - memory writes need the latch and an unprotected address, nothing overrides
// - protect enable 0 ignores the pin; 1 with pin low blocks status writes
// - the protect pin never affects memory array writes
// - status read shifts out the current status byte
// - permitted status write updates protect enable and both block bits
// - factory status value is all zeros
// - burst write hitting protected address stops incrementing and drops data
`timescale 1ns/100ps
`default_nettype none
module sfw_core (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // serial pins
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_SCK,
  input  wire logic        SPI_SI,
  input  wire logic        WP_N,
  output logic             SPI_SO,
  output logic             SPI_SO_OE,
  // nonvolatile protect bits: {enable, block high, block low}
  input  wire logic [2:0]  NV_RESTORE,
  output logic [2:0]       NV_STORE,
  // memory array write port
  output logic             MEM_WR_STB,
  output logic [14:0]      MEM_WR_ADDR,
  output logic [7:0]       MEM_WR_DATA,
  // commands served elsewhere
  output logic             CMD_STB,
  output logic [7:0]       CMD_OP
);

  sfw_link_if link ();

  logic       wp_n_s;
  logic [2:0] nv_s;

  sfw_spi_front u_front (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .cs_n_pin  (SPI_CS_N),
    .sck_pin   (SPI_SCK),
    .si_pin    (SPI_SI),
    .wp_n_pin  (WP_N),
    .nv_pin    (NV_RESTORE),
    .wp_n_sync (wp_n_s),
    .nv_sync   (nv_s),
    .so        (SPI_SO),
    .so_oe     (SPI_SO_OE),
    .link      (link)
  );

  sfw_pkg::sfw_state_e state_r, state_nxt;
  logic        wel_r, wel_nxt, protect_pin_enable_r, protect_pin_enable_nxt, clr_pend_r, clr_pend_nxt;
  logic        halt_r, halt_nxt;
  logic [1:0]  bp_r, bp_nxt;
  logic [14:0] addr_r, addr_nxt, wr_addr_r, wr_addr_nxt;
  logic [7:0]  wr_data_r, wr_data_nxt, tx_byte_r, tx_byte_nxt, cmd_op_r, cmd_op_nxt;
  logic        wr_stb_r, wr_stb_nxt, cmd_stb_r, cmd_stb_nxt;
  logic        tx_load_r, tx_load_nxt, tx_en_r, tx_en_nxt;
  logic [7:0]  status_byte;
  logic        sr_locked;

  // status image; unlisted bits stay zero
  always_comb begin
    status_byte                       = 8'h00;
    status_byte[sfw_pkg::SR_PROTECT_PIN_ENABLE_BIT]  = protect_pin_enable_r;
    status_byte[sfw_pkg::SR_BP_HI_BIT] = bp_r[1];
    status_byte[sfw_pkg::SR_BP_LO_BIT] = bp_r[0];
    status_byte[sfw_pkg::SR_WEL_BIT]   = wel_r;
  end

  // the pin only guards the status register, never the array
  assign sr_locked = protect_pin_enable_r & ~wp_n_s;

  assign link.tx_load = tx_load_r;
  assign link.tx_byte = tx_byte_r;
  assign link.tx_en   = tx_en_r;
  assign NV_STORE     = {protect_pin_enable_r, bp_r};
  assign MEM_WR_STB   = wr_stb_r;
  assign MEM_WR_ADDR  = wr_addr_r;
  assign MEM_WR_DATA  = wr_data_r;
  assign CMD_STB      = cmd_stb_r;
  assign CMD_OP       = cmd_op_r;

  // command sequencer
  always_comb begin
    state_nxt    = state_r;
    wel_nxt      = wel_r;
    protect_pin_enable_nxt     = protect_pin_enable_r;
    bp_nxt       = bp_r;
    clr_pend_nxt = clr_pend_r;
    halt_nxt     = halt_r;
    addr_nxt     = addr_r;
    wr_addr_nxt  = wr_addr_r;
    wr_data_nxt  = wr_data_r;
    wr_stb_nxt   = 1'h0;
    cmd_stb_nxt  = 1'h0;
    cmd_op_nxt   = cmd_op_r;
    tx_load_nxt  = 1'h0;
    tx_byte_nxt  = tx_byte_r;
    tx_en_nxt    = tx_en_r;
    if (link.cs_rise) begin
      // deselect ends every operation and applies any pending latch clear
      if (clr_pend_r) begin
        wel_nxt = 1'h0;
      end
      clr_pend_nxt = 1'h0;
      tx_en_nxt    = 1'h0;
      state_nxt    = sfw_pkg::ST_IDLE;
    end else if (link.cs_fall) begin
      state_nxt    = sfw_pkg::ST_OPCODE;
      clr_pend_nxt = 1'h0;
      halt_nxt     = 1'h0;
      tx_en_nxt    = 1'h0;
    end else if (link.rx_valid) begin
      case (state_r)
        sfw_pkg::ST_OPCODE: begin
          // only a whole byte is decoded, so a short frame does nothing
          case (link.rx_byte)
            sfw_pkg::OP_LATCH_SET: begin
              wel_nxt   = 1'h1;
              state_nxt = sfw_pkg::ST_PASS;
            end
            sfw_pkg::OP_LATCH_RESET: begin
              clr_pend_nxt = 1'h1;
              state_nxt    = sfw_pkg::ST_PASS;
            end
            sfw_pkg::OP_STATUS_READ: begin
              tx_load_nxt = 1'h1;
              tx_byte_nxt = status_byte;
              tx_en_nxt   = 1'h1;
              state_nxt   = sfw_pkg::ST_SR_OUT;
            end
            sfw_pkg::OP_STATUS_WRITE: begin
              clr_pend_nxt = 1'h1;
              state_nxt    = sfw_pkg::ST_SR_DATA;
            end
            sfw_pkg::OP_MEM_WRITE: begin
              clr_pend_nxt = 1'h1;
              state_nxt    = sfw_pkg::ST_ADDR_HI;
            end
            sfw_pkg::OP_MEM_READ, sfw_pkg::OP_FAST_READ,
            sfw_pkg::OP_SLEEP, sfw_pkg::OP_IDENT_READ: begin
              cmd_stb_nxt = 1'h1;
              cmd_op_nxt  = link.rx_byte;
              state_nxt   = sfw_pkg::ST_PASS;
            end
            default: begin
              state_nxt = sfw_pkg::ST_IGNORE;
            end
          endcase
        end
        sfw_pkg::ST_ADDR_HI: begin
          // top address bit is a don't-care
          addr_nxt  = {link.rx_byte[6:0], addr_r[7:0]};
          state_nxt = sfw_pkg::ST_ADDR_LO;
        end
        sfw_pkg::ST_ADDR_LO: begin
          addr_nxt  = {addr_r[14:8], link.rx_byte};
          state_nxt = sfw_pkg::ST_WDATA;
        end
        sfw_pkg::ST_WDATA: begin
          if (halt_r || sfw_pkg::is_protected(bp_r, addr_r)) begin
            halt_nxt = 1'h1;
          end else if (wel_r) begin
            wr_stb_nxt  = 1'h1;
            wr_addr_nxt = addr_r;
            wr_data_nxt = link.rx_byte;
            addr_nxt    = addr_r + 15'h0001;
          end
        end
        sfw_pkg::ST_SR_DATA: begin
          // latch and fixed-zero positions in the data byte are dropped
          if (wel_r && !sr_locked) begin
            protect_pin_enable_nxt = link.rx_byte[sfw_pkg::SR_PROTECT_PIN_ENABLE_BIT];
            bp_nxt   = {link.rx_byte[sfw_pkg::SR_BP_HI_BIT], link.rx_byte[sfw_pkg::SR_BP_LO_BIT]};
          end
          state_nxt = sfw_pkg::ST_PASS;
        end
        sfw_pkg::ST_SR_OUT: begin
          tx_load_nxt = 1'h1;
          tx_byte_nxt = status_byte;
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  // restore bits are reloaded while reset is held; latch always starts clear
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_r    <= sfw_pkg::ST_IDLE;
      wel_r      <= sfw_pkg::WEL_RESET;
      protect_pin_enable_r     <= nv_s[2];
      bp_r       <= nv_s[1:0];
      clr_pend_r <= 1'h0;
      halt_r     <= 1'h0;
      addr_r     <= sfw_pkg::ADDR_RESET;
      wr_addr_r  <= sfw_pkg::ADDR_RESET;
      wr_data_r  <= 8'h00;
      wr_stb_r   <= 1'h0;
      cmd_stb_r  <= 1'h0;
      cmd_op_r   <= 8'h00;
      tx_load_r  <= 1'h0;
      tx_byte_r  <= sfw_pkg::STATUS_FACTORY;
      tx_en_r    <= 1'h0;
    end else begin
      state_r    <= state_nxt;
      wel_r      <= wel_nxt;
      protect_pin_enable_r     <= protect_pin_enable_nxt;
      bp_r       <= bp_nxt;
      clr_pend_r <= clr_pend_nxt;
      halt_r     <= halt_nxt;
      addr_r     <= addr_nxt;
      wr_addr_r  <= wr_addr_nxt;
      wr_data_r  <= wr_data_nxt;
      wr_stb_r   <= wr_stb_nxt;
      cmd_stb_r  <= cmd_stb_nxt;
      cmd_op_r   <= cmd_op_nxt;
      tx_load_r  <= tx_load_nxt;
      tx_byte_r  <= tx_byte_nxt;
      tx_en_r    <= tx_en_nxt;
    end
  end

  // checks on the command sequencer
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_opcode(logic [7:0] op);
    state_r == sfw_pkg::ST_OPCODE && link.rx_valid && !link.cs_rise && !link.cs_fall
      && link.rx_byte == op;
  endsequence

  // a data byte taken while the status register is open for writing
  sequence s_status_data_open;
    state_r == sfw_pkg::ST_SR_DATA && link.rx_valid && !link.cs_rise && wel_r && !sr_locked;
  endsequence

  a_latch_set_done: assert property (s_opcode(sfw_pkg::OP_LATCH_SET) |=> wel_r)
    else $error("latch not set after latch-set opcode");

  a_latch_only_set: assert property ($rose(wel_r) |-> $past(link.rx_valid)
      && $past(link.rx_byte) == sfw_pkg::OP_LATCH_SET)
    else $error("latch rose without latch-set opcode");

  a_latch_clear_rise: assert property (clr_pend_r && link.cs_rise |=> !wel_r [*2])
    else $error("latch not cleared at deselect");

  a_latch_reset_pend: assert property (s_opcode(sfw_pkg::OP_LATCH_RESET) |=> clr_pend_r)
    else $error("latch-reset did not arm the latch clear");

  a_status_read_load: assert property (s_opcode(sfw_pkg::OP_STATUS_READ)
      |=> tx_load_r && tx_en_r && tx_byte_r == $past(status_byte))
    else $error("status byte not loaded after status read");

  a_status_zero_bits: assert property (tx_load_r |-> tx_byte_r[6:4] == 3'h0
      && !tx_byte_r[0])
    else $error("fixed status bits not zero");

  a_status_write_bits: assert property (s_status_data_open
      |=> (status_byte & 8'h8C) == ($past(link.rx_byte) & 8'h8C))
    else $error("permitted status write did not take the writable bits");

  a_status_locked_pin: assert property (state_r == sfw_pkg::ST_SR_DATA && link.rx_valid
      && !link.cs_rise && sr_locked |=> $stable(bp_r) && $stable(protect_pin_enable_r))
    else $error("status written while pin lock active");

  a_mem_wr_guard: assert property (wr_stb_nxt |-> wel_r
      && !sfw_pkg::is_protected(bp_r, addr_r) ##1 wr_stb_r)
    else $error("memory write issued without latch or into protected range");

  a_burst_halt: assert property (halt_r && state_r == sfw_pkg::ST_WDATA
      |=> $stable(addr_r) && !wr_stb_r)
    else $error("halted burst still advanced or wrote");

  a_invalid_quiet: assert property (state_r == sfw_pkg::ST_IGNORE
      |-> !tx_en_r && !wr_stb_r && !cmd_stb_r)
    else $error("activity after invalid opcode");

  a_cmd_strobe_op: assert property (s_opcode(sfw_pkg::OP_FAST_READ)
      |=> cmd_stb_r && cmd_op_r == sfw_pkg::OP_FAST_READ)
    else $error("fast read opcode gave no command strobe");

  a_deselect_quiet: assert property (link.cs_rise |=> !tx_en_r && !SPI_SO_OE)
    else $error("output still enabled after deselect");

endmodule
`default_nettype wire

// [sfw_pkg.sv]
`default_nettype none
package sfw_pkg;

  // command opcodes
  localparam logic [7:0] OP_LATCH_SET    = 8'h06;
  localparam logic [7:0] OP_LATCH_RESET  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ     = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_MEM_WRITE    = 8'h02;
  localparam logic [7:0] OP_SLEEP        = 8'hB9;
  localparam logic [7:0] OP_IDENT_READ   = 8'h9F;

  // status register layout
  localparam int SR_PROTECT_PIN_ENABLE_BIT  = 7;
  localparam int SR_BP_HI_BIT = 3;
  localparam int SR_BP_LO_BIT = 2;
  localparam int SR_WEL_BIT   = 1;

  // reset and factory values
  localparam logic [7:0] STATUS_FACTORY = 8'h00;
  localparam logic       WEL_RESET      = 1'h0;

  // address space and protected ranges
  localparam int          ADDR_W            = 15;
  localparam logic [14:0] ADDR_RESET        = 15'h0000;
  localparam logic [14:0] PROT_QUARTER_BASE = 15'h6000;
  localparam logic [14:0] PROT_HALF_BASE    = 15'h4000;

  // pin synchroniser width: cs_n, sck, si, wp_n, three restore bits
  localparam int SYNC_W = 7;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA,
    ST_SR_DATA, ST_SR_OUT, ST_PASS, ST_IGNORE
  } sfw_state_e;

  // true when the block-protect setting covers this address
  function automatic logic is_protected(input logic [1:0] bp, input logic [14:0] addr);
    case (bp)
      2'h1:    return addr >= PROT_QUARTER_BASE;
      2'h2:    return addr >= PROT_HALF_BASE;
      2'h3:    return 1'h1;
      default: return 1'h0;
    endcase
  endfunction

endpackage
`default_nettype wire

// [sfw_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface sfw_link_if;
  logic       sel;
  logic       cs_fall;
  logic       cs_rise;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       tx_load;
  logic [7:0] tx_byte;
  logic       tx_en;

  modport front (output sel, output cs_fall, output cs_rise, output rx_valid,
                 output rx_byte, input tx_load, input tx_byte, input tx_en);
  modport core  (input sel, input cs_fall, input cs_rise, input rx_valid,
                 input rx_byte, output tx_load, output tx_byte, output tx_en);
endinterface
`default_nettype wire

// [sfw_spi_front.sv]
`timescale 1ns/100ps
`default_nettype none
module sfw_spi_front (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // raw pins
  input  wire logic        cs_n_pin,
  input  wire logic        sck_pin,
  input  wire logic        si_pin,
  input  wire logic        wp_n_pin,
  input  wire logic [2:0]  nv_pin,
  // synchronised levels and serial output
  output logic             wp_n_sync,
  output logic [2:0]       nv_sync,
  output logic             so,
  output logic             so_oe,
  // byte link to the command core
  sfw_link_if.front        link
);

  logic [sfw_pkg::SYNC_W-1:0] meta_r;
  logic [sfw_pkg::SYNC_W-1:0] sync_r;
  logic       sck_d_r, cs_d_r;
  logic [7:0] rx_sh_r, rx_sh_nxt, rx_byte_r, rx_byte_nxt, tx_sh_r, tx_sh_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic       rx_valid_r, rx_valid_nxt, so_r, so_nxt, so_oe_r, so_oe_nxt;
  logic       cs_n_s, sck_s, si_s, sck_rise, sck_fall;

  // two-stage synchroniser; no reset so restore bits flow through during reset
  always_ff @(posedge clk) begin
    meta_r <= {nv_pin, wp_n_pin, si_pin, sck_pin, cs_n_pin};
    sync_r <= meta_r;
  end

  assign cs_n_s    = sync_r[0];
  assign sck_s     = sync_r[1];
  assign si_s      = sync_r[2];
  assign wp_n_sync = sync_r[3];
  assign nv_sync   = sync_r[6:4];
  assign sck_rise  = sck_s & ~sck_d_r;
  assign sck_fall  = ~sck_s & sck_d_r;

  // framing strobes from the synchronised select
  assign link.sel     = ~cs_n_s;
  assign link.cs_fall = ~cs_n_s & cs_d_r;
  assign link.cs_rise = cs_n_s & ~cs_d_r;
  assign link.rx_valid = rx_valid_r;
  assign link.rx_byte  = rx_byte_r;
  assign so    = so_r;
  assign so_oe = so_oe_r;

  // shift in on rising sck, shift out on falling sck, mode 0 and mode 3 alike
  always_comb begin
    rx_sh_nxt    = rx_sh_r;
    rx_byte_nxt  = rx_byte_r;
    bit_cnt_nxt  = bit_cnt_r;
    rx_valid_nxt = 1'h0;
    tx_sh_nxt    = tx_sh_r;
    so_nxt       = so_r;
    if (link.cs_fall) begin
      bit_cnt_nxt = 3'h0;
    end else if (link.sel && sck_rise) begin
      rx_sh_nxt   = {rx_sh_r[6:0], si_s};
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        rx_valid_nxt = 1'h1;
        rx_byte_nxt  = {rx_sh_r[6:0], si_s};
      end
    end
    // a load always lands between the last rising edge and the next falling one
    if (link.tx_load) begin
      tx_sh_nxt = link.tx_byte;
    end else if (link.sel && link.tx_en && sck_fall) begin
      so_nxt    = tx_sh_r[7];
      tx_sh_nxt = {tx_sh_r[6:0], 1'h0};
    end
    if (!link.sel) begin
      so_nxt = 1'h0;
    end
    so_oe_nxt = link.sel & link.tx_en;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_d_r    <= 1'h0;
      cs_d_r     <= 1'h1;
      rx_sh_r    <= 8'h00;
      rx_byte_r  <= 8'h00;
      bit_cnt_r  <= 3'h0;
      rx_valid_r <= 1'h0;
      tx_sh_r    <= 8'h00;
      so_r       <= 1'h0;
      so_oe_r    <= 1'h0;
    end else begin
      sck_d_r    <= sck_s;
      cs_d_r     <= cs_n_s;
      rx_sh_r    <= rx_sh_nxt;
      rx_byte_r  <= rx_byte_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      rx_valid_r <= rx_valid_nxt;
      tx_sh_r    <= tx_sh_nxt;
      so_r       <= so_nxt;
      so_oe_r    <= so_oe_nxt;
    end
  end

endmodule
`default_nettype wire

// [sfw_spi_master.sv]
`timescale 1ns/100ps
`default_nettype none
module sfw_spi_master (
  // pacing clock
  input  wire logic clk,
  // serial bus towards the device
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      wp_n,
  input  wire logic so
);
  localparam int HALF = 4; // sck half period in clk cycles, 400 ns

  logic [7:0] rx_byte;
  logic       cpol; // 0 for mode 0, 1 for mode 3

  // clock idles at cpol and stands still between frames
  initial begin
    cpol    = 1'b0;
    cs_n    = 1'b1;
    sck     = 1'b0;
    si      = 1'b1;
    wp_n    = 1'b1;
    rx_byte = 8'h00;
  end

  // every pin change lands on a falling clk edge
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // msb first; so is taken late in the high phase, where it surely stands
  task automatic shift(input logic [7:0] tx, input int nbits);
    for (int i = 7; i > 7 - nbits; i--) begin
      if (cpol)
        sck = 1'b0; // mode 3 opens each bit with a fall
      si = tx[i];
      idle(HALF);
      sck = 1'b1;
      idle(HALF - 1);
      rx_byte[i] = so;
      idle(1);
      if (!cpol)
        sck = 1'b0;
    end
  endtask

  // one select period; the last byte may be cut short to test partial bytes
  task automatic frame(input logic [63:0] data, input int nbytes, input int lastbits);
    cs_n = 1'b0;
    idle(HALF);
    for (int b = 0; b < nbytes; b++)
      shift(data[63-8*b -: 8], (b == nbytes - 1) ? lastbits : 8);
    idle(HALF);
    cs_n = 1'b1;
    si = ~si;    // released line shows the inverse, never the stale bit
    idle(4 * HALF);
  endtask
endmodule
`default_nettype wire

// [sfw_core_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module sfw_core_tb;
  logic        clk_sys;
  logic        rst_n;
  logic [2:0]  nv_restore;
  wire         cs_n;
  wire         sck;
  wire         si;
  wire         wp_n;
  logic        so;
  logic        so_oe;
  logic [2:0]  nv_store;
  logic        mem_wr_stb;
  logic [14:0] mem_wr_addr;
  logic [7:0]  mem_wr_data;
  logic        cmd_stb;
  logic [7:0]  cmd_op;
  logic [22:0] wr_q[$];
  logic [7:0]  cmd_last;
  int          cmd_cnt;
  int          oe_cnt;
  int          miscompares;
  int          checked;

  sfw_core DUT (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_SI(si),
    .WP_N(wp_n), .SPI_SO(so), .SPI_SO_OE(so_oe), .NV_RESTORE(nv_restore),
    .NV_STORE(nv_store), .MEM_WR_STB(mem_wr_stb), .MEM_WR_ADDR(mem_wr_addr),
    .MEM_WR_DATA(mem_wr_data), .CMD_STB(cmd_stb), .CMD_OP(cmd_op));

  sfw_spi_master m (.clk(clk_sys), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so));

  always #50 clk_sys = ~clk_sys;

  // record strobes and output-enable cycles as the design produces them
  always @(posedge clk_sys) begin
    if (mem_wr_stb === 1'b1)
      wr_q.push_back({mem_wr_addr, mem_wr_data});
    if (cmd_stb === 1'b1) begin
      cmd_cnt++;
      cmd_last = cmd_op;
    end
    if (so_oe === 1'b1)
      oe_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // restore bits pass a two-flop sync, so reset is held three edges
  task automatic do_reset(input logic [2:0] nv);
    rst_n = 1'b0;
    nv_restore = nv;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic rd_status(input logic [7:0] exp);
    int o0;
    o0 = oe_cnt;
    m.frame({sfw_pkg::OP_STATUS_READ, 56'h0}, 2, 8);
    check(32'(m.rx_byte), 32'(exp));
    check(32'(oe_cnt > o0), 32'h1);
    check(32'({so_oe, so}), 32'h0);
  endtask

  task automatic wr_status(input logic [7:0] v, input logic latch);
    if (latch)
      m.frame({sfw_pkg::OP_LATCH_SET, 56'h0}, 1, 8);
    m.frame({sfw_pkg::OP_STATUS_WRITE, v, 48'h0}, 2, 8);
  endtask

  task automatic t_reset();
    check(32'(nv_store), 32'h0);
    check(32'({so_oe, so}), 32'h0);
    check(32'(cmd_cnt), 32'h0);
    rd_status(8'h00);
    $display("test reset done");
  endtask

  task automatic t_latch();
    m.frame({sfw_pkg::OP_LATCH_SET, 56'h0}, 1, 7);
    rd_status(8'h00);
    m.frame({sfw_pkg::OP_LATCH_SET, 56'h0}, 1, 8);
    rd_status(8'h02);
    rd_status(8'h02);
    m.frame({sfw_pkg::OP_LATCH_RESET, 56'h0}, 1, 8);
    rd_status(8'h00);
    $display("test latch done");
  endtask

  // full-byte latch set and reset traffic with the clock idling high
  task automatic t_mode3();
    m.cpol = 1'b1;
    m.sck  = 1'b1;
    m.idle(8);
    m.frame({sfw_pkg::OP_LATCH_SET, 56'h0}, 1, 8);
    rd_status(8'h02);
    m.frame({sfw_pkg::OP_LATCH_RESET, 56'h0}, 1, 8);
    rd_status(8'h00);
    m.cpol = 1'b0;
    m.sck  = 1'b0;
    m.idle(8);
    $display("test mode 3 done");
  endtask

  task automatic t_cmds();
    logic [7:0] ops [4] = '{sfw_pkg::OP_MEM_READ, sfw_pkg::OP_FAST_READ,
                            sfw_pkg::OP_IDENT_READ, sfw_pkg::OP_SLEEP};
    int c0;
    for (int i = 0; i < 4; i++) begin
      c0 = cmd_cnt;
      m.frame({ops[i], 56'h0}, 1, 8);
      check(32'(cmd_cnt - c0), 32'h1);
      check(32'(cmd_last), 32'(ops[i]));
    end
    $display("test commands done");
  endtask

  // a latch-set and status write hidden behind a reserved opcode must die
  task automatic t_reserved();
    logic [7:0] ops [4] = '{8'hC3, 8'hC2, 8'h5A, 8'h5B};
    int c0;
    int o0;
    for (int i = 0; i < 4; i++) begin
      c0 = cmd_cnt;
      o0 = oe_cnt;
      wr_q.delete();
      m.frame({ops[i], sfw_pkg::OP_LATCH_SET, sfw_pkg::OP_STATUS_WRITE, 8'h8C, 32'h0}, 4, 8);
      check(32'(cmd_cnt - c0 + oe_cnt - o0 + wr_q.size()), 32'h0);
      rd_status(8'h00);
    end
    $display("test reserved done");
  endtask

  task automatic t_status();
    wr_status(8'hFF, 1'b0);
    rd_status(8'h00);
    wr_status(8'hFF, 1'b1);
    rd_status(8'h8C);
    check(32'(nv_store), 32'h7);
    m.wp_n = 1'b0;
    wr_status(8'h00, 1'b1);
    rd_status(8'h8C);
    m.wp_n = 1'b1;
    wr_status(8'h84, 1'b1);
    rd_status(8'h84);
    wr_status(8'h04, 1'b1);
    m.wp_n = 1'b0;
    wr_status(8'h08, 1'b1);
    rd_status(8'h08);
    m.wp_n = 1'b1;
    $display("test status done");
  endtask

  // bursts run into each protect boundary; the pin is held low throughout
  task automatic t_mem();
    logic [7:0]  sr  [5] = '{8'h00, 8'h84, 8'h08, 8'h0C, 8'h00};
    logic [15:0] adr [5] = '{16'hFFFE, 16'h5FFE, 16'h3FFF, 16'h0000, 16'h0010};
    int          nd  [5] = '{3, 4, 3, 2, 2};
    int          ok  [5] = '{3, 2, 1, 0, 0};
    for (int i = 0; i < 5; i++) begin
      wr_status(sr[i], 1'b1);
      rd_status(sr[i]);
      if (i != 4)
        m.frame({sfw_pkg::OP_LATCH_SET, 56'h0}, 1, 8);
      m.wp_n = 1'b0;
      wr_q.delete();
      m.frame({sfw_pkg::OP_MEM_WRITE, adr[i], 40'hA1A2A3A4A5}, 3 + nd[i], 8);
      m.wp_n = 1'b1;
      check(32'(wr_q.size()), 32'(ok[i]));
      for (int k = 0; k < wr_q.size(); k++)
        check(32'(wr_q[k]), {9'h0, 15'(adr[i][14:0] + 15'(k)), 8'hA1 + 8'(k)});
      rd_status(sr[i]);
    end
    $display("test memory write done");
  endtask

  task automatic t_restore();
    do_reset(3'h5);
    check(32'(nv_store), 32'h5);
    rd_status(8'h84);
    do_reset(3'h0);
    rd_status(8'h00);
    $display("test restore done");
  endtask

  initial begin
    clk_sys = 1'b0;
    do_reset(3'h0);
    t_reset();
    t_latch();
    t_mode3();
    t_cmds();
    t_reserved();
    t_status();
    t_mem();
    t_restore();
    tally_and_finish();
  end

  // the whole run needs about 1.1 ms; cut a hang well after that
  initial begin
    #6_000_000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
